// *** cocb_defs.svh ***
/*
 clock output control bytes: register indexes, field positions, reset values
 and serial framing constants. assumes inclusion by bare name.
*/
`ifndef COCB_DEFS_SVH
`define COCB_DEFS_SVH
`define COCB_SLAVE_ADDR 7'h69
`define COCB_CMD_CODE 8'h00
`define COCB_MAX_COUNT 8'h20
`define COCB_NUM_BYTES 3'h5
`define COCB_IDX_CTRL 3'h0
`define COCB_IDX_CPU 3'h1
`define COCB_IDX_BUS 3'h2
`define COCB_IDX_FIXED 3'h3
`define COCB_IDX_MID 3'h4
`define COCB_B0_SPREAD 7
`define COCB_B0_HUB_SEL 5
`define COCB_B0_HALT_PIN 4
`define COCB_B0_BUS_HALT 3
`define COCB_RST_B0 8'h00
`define COCB_RST_B1 8'h07
`define COCB_RST_B2 8'h7F
`define COCB_RST_B3 8'hC7
`define COCB_RST_B4 8'h3F
`define COCB_WMASK_B0 8'hA8
`define COCB_WMASK_B1 8'h3F
`define COCB_WMASK_B2 8'h7F
`define COCB_WMASK_B3 8'hFF
`define COCB_WMASK_B4 8'h3F
`endif

// *** cocb_pkg.sv ***
/*
 types for the clock output control bytes. assumes cocb_defs.svh nearby.
*/
package cocb_pkg;
   typedef enum logic [2:0] {
      COCB_IDLE = 3'h0,
      COCB_ADDR = 3'h1,
      COCB_CMD = 3'h3,
      COCB_COUNT = 3'h2,
      COCB_DATA = 3'h6,
      COCB_IGNORE = 3'h7
   } cocb_state_t;
endpackage

// *** cocb_clk_gate.sv ***
/*
 glitch-free stop of one clock output. assumes clk_in is a level stream
 with phases of one or more ref_clk cycles, sampled on ref_clk; stopping waits for the low phase.
*/
`timescale 1ns/1ps
module cocb_clk_gate (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // clock stream and run request
   input wire logic clk_in,
   input wire logic run,
   // gated output
   output logic clk_out
);
   logic run_ff;
   logic out_ff;
   // the run decision only changes while the source is low, so the current
   // high phase always completes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_ff <= 1'b0;
      end else if (!clk_in) begin
         run_ff <= run;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= 1'b0;
      end else begin
         out_ff <= clk_in & run_ff;
      end
   end
   assign clk_out = out_ff;
endmodule

// *** cocb_regs.sv ***
/*
 clock output control bytes 0..4 with a two-wire block-write receiver and
 glitch-free output gating. assumes scl/sda inputs are synchronous to
 ref_clk and the clock sources arrive as sampled level streams.
*/
`timescale 1ns/1ps
`include "cocb_defs.svh"
module cocb_regs (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // serial management pins
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // straps and halt pins
   input wire logic [2:0] freq_select,
   input wire logic cpu_halt_n,
   // clock sources
   input wire logic src_cpu,
   input wire logic src_bus,
   input wire logic src_mid,
   input wire logic src_48,
   // control outputs
   output logic spread_en,
   output logic hub_sel_48,
   output logic [4:0] mid_rate_en,
   // gated clocks
   output logic [2:0] cpu_clk,
   output logic [6:0] bus_clk,
   output logic [2:0] bus_free_clk,
   output logic [2:0] buffered_66_clock,
   output logic mid_rate_clock_zero,
   output logic graphics_hub_clock,
   output logic mid_rate_clock_five,
   output logic display_48_clock,
   output logic usb_48_clock
);
   logic [7:0] reg_ff [5];
   logic [2:0] strap_ff;
   logic strap_done_ff;
   logic scl_d_ff, sda_d_ff;
   cocb_pkg::cocb_state_t st_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic [5:0] left_ff;
   logic [2:0] idx_ff;
   logic ack_ff;
   logic start_c, stop_c, rise_c, fall_c, byte_c;
   logic byte_ok, due_ff;
   logic [7:0] rbyte;

   function automatic logic [7:0] wmask(input logic [2:0] i);
      case (i)
         3'h0: wmask = `COCB_WMASK_B0;
         3'h1: wmask = `COCB_WMASK_B1;
         3'h2: wmask = `COCB_WMASK_B2;
         3'h3: wmask = `COCB_WMASK_B3;
         default: wmask = `COCB_WMASK_B4;
      endcase
   endfunction

   assign rise_c = scl & ~scl_d_ff;
   assign fall_c = ~scl & scl_d_ff;
   assign start_c = scl & scl_d_ff & sda_d_ff & ~sda_in;
   assign stop_c = scl & scl_d_ff & ~sda_d_ff & sda_in;
   assign byte_c = rise_c && bit_ff == 4'h7;
   assign rbyte = {sh_ff[6:0], sda_in};
   // each byte's answer is settled at its eighth bit from the state it
   // arrived in, so counters left over from an earlier frame play no part
   assign byte_ok = (st_ff == cocb_pkg::COCB_ADDR &&
      rbyte == {`COCB_SLAVE_ADDR, 1'b0}) ||
      (st_ff == cocb_pkg::COCB_CMD && rbyte == `COCB_CMD_CODE) ||
      (st_ff == cocb_pkg::COCB_COUNT && rbyte != 8'h00 &&
      rbyte <= `COCB_MAX_COUNT) ||
      (st_ff == cocb_pkg::COCB_DATA);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl;
         sda_d_ff <= sda_in;
      end
   end

   // straps caught on the first clock after reset release
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_ff <= 3'h0;
         strap_done_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_ff <= freq_select;
         strap_done_ff <= 1'b1;
      end
   end

   // bit counter and shifter; bit 8 is the acknowledge slot
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_ff <= 4'h0;
         sh_ff <= 8'h00;
      end else if (start_c || stop_c) begin
         bit_ff <= 4'h0;
      end else if (rise_c) begin
         sh_ff <= rbyte;
         bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= cocb_pkg::COCB_IDLE;
         left_ff <= 6'h00;
         idx_ff <= 3'h0;
      end else if (start_c) begin
         st_ff <= cocb_pkg::COCB_ADDR;
      end else if (stop_c) begin
         st_ff <= cocb_pkg::COCB_IDLE;
      end else if (byte_c) begin
         unique case (st_ff)
            cocb_pkg::COCB_ADDR:
               st_ff <= byte_ok ? cocb_pkg::COCB_CMD :
                  cocb_pkg::COCB_IGNORE;
            cocb_pkg::COCB_CMD:
               st_ff <= byte_ok ? cocb_pkg::COCB_COUNT :
                  cocb_pkg::COCB_IGNORE;
            cocb_pkg::COCB_COUNT: begin
               idx_ff <= `COCB_IDX_CTRL;
               left_ff <= rbyte[5:0];
               st_ff <= byte_ok ? cocb_pkg::COCB_DATA :
                  cocb_pkg::COCB_IGNORE;
            end
            cocb_pkg::COCB_DATA: begin
               // the index parks past byte 4 so long counts never wrap
               if (idx_ff < `COCB_NUM_BYTES) begin
                  idx_ff <= idx_ff + 3'h1;
               end
               left_ff <= left_ff - 6'h01;
               if (left_ff == 6'h01) begin
                  st_ff <= cocb_pkg::COCB_IGNORE;
               end
            end
            cocb_pkg::COCB_IDLE, cocb_pkg::COCB_IGNORE: ;
         endcase
      end
   end

   // answer owed for the byte just shifted in; bytes past index 4 inside
   // the count are acked but dropped, bytes past the count are not acked
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         due_ff <= 1'b0;
      end else if (start_c || stop_c) begin
         due_ff <= 1'b0;
      end else if (byte_c) begin
         due_ff <= byte_ok;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else if (start_c || stop_c) begin
         ack_ff <= 1'b0;
      end else if (fall_c && bit_ff == 4'h8) begin
         ack_ff <= due_ff;
      end else if (fall_c) begin
         ack_ff <= 1'b0;
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = ack_ff;

   // only writable positions take the data byte
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_ff[0] <= `COCB_RST_B0;
         reg_ff[1] <= `COCB_RST_B1;
         reg_ff[2] <= `COCB_RST_B2;
         reg_ff[3] <= `COCB_RST_B3;
         reg_ff[4] <= `COCB_RST_B4;
      end else if (byte_c && st_ff == cocb_pkg::COCB_DATA &&
                   idx_ff < `COCB_NUM_BYTES) begin
         reg_ff[idx_ff] <= (reg_ff[idx_ff] & ~wmask(idx_ff)) |
            (rbyte & wmask(idx_ff));
      end
   end

   // read view of byte 0; its halt and strap bits also drive mid_rate_en[1:0]
   logic [7:0] status_byte;
   assign status_byte = {reg_ff[0][7], 1'b0, reg_ff[0][5], cpu_halt_n,
      reg_ff[0][3], strap_ff};

   assign spread_en = reg_ff[0][`COCB_B0_SPREAD];
   assign hub_sel_48 = reg_ff[0][`COCB_B0_HUB_SEL];
   assign mid_rate_en = {reg_ff[4][3], reg_ff[4][4], reg_ff[4][5],
      status_byte[4], status_byte[2]};

   logic bus_halt;
   logic [2:0] cpu_run;
   logic [6:0] bus_run;
   logic [2:0] free_run;
   assign bus_halt = reg_ff[0][`COCB_B0_BUS_HALT];
   assign cpu_run = reg_ff[1][2:0] & (reg_ff[1][5:3] | {3{cpu_halt_n}});
   assign bus_run = reg_ff[2][6:0] & {7{~bus_halt}};
   assign free_run = reg_ff[3][2:0] & ~(reg_ff[3][5:3] & {3{bus_halt}});

   logic [21:1] g_src, g_run, g_out;
   assign g_src = {{3{src_cpu}}, {7{src_bus}}, {3{src_bus}}, {3{src_mid}},
      src_mid, hub_sel_48 ? src_48 : src_mid, src_mid, src_48, src_48};
   assign g_run = {cpu_run, bus_run, free_run, reg_ff[4][2:0], reg_ff[4][5],
      reg_ff[4][4], reg_ff[4][3], reg_ff[3][7], reg_ff[3][6]};

   genvar g;
   generate
      for (g = 1; g < 22; g++) begin : gate
         cocb_clk_gate u_gate (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .clk_in(g_src[g]),
            .run(g_run[g]),
            .clk_out(g_out[g])
         );
      end
   endgenerate

   assign cpu_clk = g_out[21:19];
   assign bus_clk = g_out[18:12];
   assign bus_free_clk = g_out[11:9];
   assign buffered_66_clock = g_out[8:6];
   assign mid_rate_clock_zero = g_out[5];
   assign graphics_hub_clock = g_out[4];
   assign mid_rate_clock_five = g_out[3];
   assign display_48_clock = g_out[2];
   assign usb_48_clock = g_out[1];
endmodule

// *** cocb_regs_chk.sv ***
/*
 checker for cocb_regs serial and gating ports.
 assumes one ref_clk domain; bound to every cocb_regs.
*/
`timescale 1ns/1ps
module cocb_regs_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // serial and pins
   input wire logic scl,
   input wire logic sda_oe,
   input wire logic cpu_halt_n,
   input wire logic src_cpu,
   input wire logic src_bus,
   // outputs
   input wire logic spread_en,
   input wire logic [4:0] mid_rate_en,
   input wire logic [2:0] cpu_clk,
   input wire logic [6:0] bus_clk
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   sequence pin_steady;
      $stable(cpu_halt_n) [*3];
   endsequence
   sequence ack_high;
      sda_oe && scl;
   endsequence
   wr_on_scl_a: assert property (
      $changed({spread_en, mid_rate_en[4:2]}) |-> scl)
      else $error("register moved with scl low");
   ack_rise_a: assert property (
      $rose(sda_oe) |-> !scl)
      else $error("ack began with scl high");
   ack_hold_a: assert property (
      ack_high |=> sda_oe || !scl)
      else $error("ack dropped in scl high");
   halt_live_a: assert property (
      pin_steady |-> mid_rate_en[1] == cpu_halt_n)
      else $error("halt view differs from pin");
   strap_once_a: assert property (
      $past(rst_n, 3) |-> $stable(mid_rate_en[0]))
      else $error("strap view moved");
   cpu_rise_a: assert property (
      $rose(cpu_clk[0]) |-> $past(src_cpu))
      else $error("cpu clock rose without source");
   bus_fall_a: assert property (
      $fell(bus_clk[0]) |-> !$past(src_bus))
      else $error("bus clock cut short");
   bus_high_a: assert property (
      bus_clk[6] |-> $past(src_bus))
      else $error("bus clock high without source");
endmodule
bind cocb_regs cocb_regs_chk u_chk (.ref_clk, .rst_n, .scl, .sda_oe,
   .cpu_halt_n, .src_cpu, .src_bus, .spread_en, .mid_rate_en, .cpu_clk,
   .bus_clk);

// *** cocb_host.sv ***
/*
 host model for block writes on the two-wire bus.
 assumes the device pulls data low through sda_oe.
*/
`timescale 1ns/1ps
module cocb_host (
   // clock
   input wire logic ref_clk,
   // device pull-down
   input wire logic sda_oe,
   // bus lines
   output logic scl,
   output logic sda_in
);
   logic sda_drv = 1'h1;
   // pull-up: data reads high unless a party pulls low
   assign sda_in = sda_drv & ~sda_oe;
   initial scl = 1'h1;
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic pulse(input logic v, output logic low);
      sda_drv = v;
      tick(4);
      scl = 1'h1;
      tick(4);
      low = ~sda_in;
      scl = 1'h0;
      tick(4);
   endtask
   task automatic xfer(input logic [23:0] h, input logic [39:0] d,
      input logic [2:0] n, output logic [7:0] acks);
      logic [63:0] all;
      logic a;
      all = {h, d};
      acks = 8'h00;
      sda_drv = 1'h0;
      tick(4);
      scl = 1'h0;
      for (int k = 0; k < 3 + n; k++) begin
         for (int i = 63 - 8 * k; i > 55 - 8 * k; i--) begin
            pulse(all[i], a);
         end
         pulse(1'h1, a);
         acks = acks + {7'h00, a};
      end
      sda_drv = 1'h0;
      tick(4);
      scl = 1'h1;
      tick(4);
      sda_drv = 1'h1;
      tick(8);
   endtask
endmodule

// *** cocb_regs_tb.sv ***
/*
 bench for cocb_regs: a table of block writes, then halt and reset cases.
 assumes cocb_host drives the serial lines.
*/
`timescale 1ns/1ps
module cocb_regs_tb;
   typedef struct {
      logic [23:0] h;
      logic [39:0] d;
      logic [2:0] n;
      logic [7:0] a;
      logic [4:0] r;
      logic [20:0] q;
   } cocb_row_t;
   logic ref_clk = 1'h0, rst_n = 1'h0, cpu_halt_n = 1'h1;
   logic [2:0] freq_select = 3'h5;
   logic [1:0] div = 2'h0;
   logic scl, sda_in, sda_out, sda_oe, spread_en, hub_sel_48;
   logic [4:0] mid_rate_en;
   logic [2:0] cpu_clk, bus_free_clk, buffered_66_clock;
   logic [6:0] bus_clk;
   logic mid_rate_clock_zero, graphics_hub_clock, mid_rate_clock_five;
   logic display_48_clock, usb_48_clock;
   logic [20:0] seen;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   logic [7:0] acks;
   // the dual pin is an output here, so byte 4 bit 3 may be cleared
   cocb_row_t rows [10] = '{
      '{24'hD20005, 40'h8000000000, 3'h5, 8'h08, 5'h10, 21'h000000},
      '{24'hD20005, 40'h283F7FFF3F, 3'h5, 8'h08, 5'h0F, 21'h1C00FF},
      '{24'hD20005, 40'h0000000000, 3'h1, 8'h04, 5'h07, 21'h1FFFFF},
      '{24'hD40005, 40'h8000000000, 3'h5, 8'h00, 5'h07, 21'h1FFFFF},
      '{24'hD20000, 40'h8000000000, 3'h1, 8'h02, 5'h07, 21'h1FFFFF},
      '{24'hD20021, 40'h8000000000, 3'h1, 8'h02, 5'h07, 21'h1FFFFF},
      '{24'hD20002, 40'h0002000000, 3'h5, 8'h05, 5'h07, 21'h0BFFFF},
      '{24'hD20005, 40'hFFC08038C0, 3'h5, 8'h08, 5'h18, 21'h000000},
      '{24'hD20005, 40'h08077FC73F, 3'h5, 8'h08, 5'h07, 21'h1C07FF},
      '{24'hD20005, 40'h00077FC73F, 3'h5, 8'h08, 5'h07, 21'h1FFFFF}};
   always #2.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) div <= div + 2'h1;
   cocb_host u_host (.ref_clk, .sda_oe, .scl, .sda_in);
   cocb_regs dut (.ref_clk, .rst_n, .scl, .sda_in, .sda_out, .sda_oe,
      .freq_select, .cpu_halt_n, .src_cpu(div[1]), .src_bus(div[1]),
      .src_mid(div[1]), .src_48(div[0]), .spread_en, .hub_sel_48,
      .mid_rate_en, .cpu_clk, .bus_clk, .bus_free_clk, .buffered_66_clock,
      .mid_rate_clock_zero, .graphics_hub_clock, .mid_rate_clock_five,
      .display_48_clock, .usb_48_clock);
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // gated clocks settle first, then every output that ran is seen high
   // the hub output must follow the 48 source when selected, else mid-rate
   task automatic look;
      logic hub_bad;
      hub_bad = 1'h0;
      repeat (8) @(negedge ref_clk);
      seen = 21'h0;
      repeat (24) begin
         @(negedge ref_clk);
         seen = seen | {cpu_clk, bus_clk, bus_free_clk, buffered_66_clock,
            mid_rate_clock_zero, graphics_hub_clock, mid_rate_clock_five,
            display_48_clock, usb_48_clock};
         if (graphics_hub_clock !== (hub_sel_48 ? display_48_clock :
            mid_rate_clock_zero)) begin
            hub_bad = 1'h1;
         end
      end
      chk(64'(hub_bad), 64'h0);
   endtask
   task automatic reset_chk;
      freq_select = 3'h5;
      rst_n = 1'h0;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'h1;
      repeat (2) @(negedge ref_clk);
      freq_select = 3'h2;
      look();
      chk(64'({sda_out, sda_oe, spread_en, hub_sel_48, mid_rate_en, seen}),
         64'({2'h0, 5'h07, cpu_halt_n, 1'h1, 21'h1FFFFF}));
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      reset_chk();
      foreach (rows[i]) begin
         u_host.xfer(rows[i].h, rows[i].d, rows[i].n, acks);
         look();
         chk(64'({acks, spread_en, hub_sel_48, mid_rate_en, seen}),
            64'({rows[i].a, rows[i].r, cpu_halt_n, 1'h1,
            rows[i].q}));
      end
      cpu_halt_n = 1'h0;
      look();
      chk(64'({mid_rate_en[1], seen}), 64'({1'h0, 21'h03FFFF}));
      u_host.xfer(24'hD20002, 40'h003F000000, 3'h2, acks);
      look();
      chk(64'(seen), 64'(21'h1FFFFF));
      cpu_halt_n = 1'h1;
      reset_chk();
      stop_test();
   end
endmodule
